// >>> bench/nsc_ctrl_asserts.sv
// Purpose: port-level checks on the nand status / column controller
// Assumes: one pclk domain, presetn async active low
// Notes:   helper regs track the last command byte and address count
`timescale 1ns/1ps
`default_nettype none
module nsc_ctrl_asserts
#(
   parameter int WHR_CYC = 3,
   parameter int ADL_CYC = 4
)
(
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic [11:0] paddr,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        nand_ce_n,
   input wire logic        nand_cle,
   input wire logic        nand_ale,
   input wire logic        nand_we_n,
   input wire logic        nand_re_n,
   input wire logic [7:0]  nand_io_o,
   input wire logic        nand_io_oe
);
   logic [7:0] cmd_r;
   logic [7:0] cmd_nxt;
   logic [2:0] acnt_r;
   logic [2:0] acnt_nxt;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // next command / address count, seen on the strobe-low clock
   always_comb
   begin
      cmd_nxt  = cmd_r;
      acnt_nxt = acnt_r;
      if (!nand_we_n && nand_cle)
      begin
         cmd_nxt  = nand_io_o;
         acnt_nxt = 3'h0;
      end
      else if (!nand_we_n && nand_ale)
         acnt_nxt = acnt_r + 3'h1;
   end
   // register only
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         cmd_r  <= 8'h00;
         acnt_r <= 3'h0;
      end
      else
      begin
         cmd_r  <= cmd_nxt;
         acnt_r <= acnt_nxt;
      end
   sequence s_cmd(logic [7:0] b);
      !nand_we_n && nand_cle && nand_io_o == b;
   endsequence
   sequence s_col2_85;
      !nand_we_n && nand_ale && cmd_r == 8'h85 && acnt_r == 3'h1;
   endsequence
   a_apb_zero_wait: assert property (psel && penable |-> pready)
      else $error("apb access phase without pready");
   a_unmapped_err: assert property (psel && penable && paddr > 12'h014 |-> pslverr)
      else $error("unmapped access without pslverr");
   a_single_target: assert property (nand_ce_n == 1'b0)
      else $error("chip enable left the target");
   a_no_contention: assert property (!nand_re_n |-> !nand_io_oe && nand_we_n)
      else $error("host drives io while reading");
   a_whr_gap: assert property (s_cmd(8'he0) |-> nand_re_n [*5])
      else $error("read strobe too soon after confirm");
   a_adl_gap: assert property (s_col2_85 |-> (nand_we_n || nand_cle || nand_ale) [*6])
      else $error("data input too soon after column");
   a_status_rows: assert property ($fell(nand_re_n) && cmd_r == 8'h78 |-> acnt_r == 3'h3)
      else $error("enhanced status without three rows");
   a_confirm_count: assert property (s_cmd(8'he0) |->
      (cmd_r == 8'h05 && acnt_r == 3'h2) || (cmd_r == 8'h06 && acnt_r == 3'h5))
      else $error("confirm after wrong address count");
   a_din_in_mode: assert property (!nand_we_n && !nand_cle && !nand_ale |->
      cmd_r == 8'h85 && acnt_r >= 3'h2)
      else $error("data input outside input mode");
endmodule : nsc_ctrl_asserts
bind nsc_ctrl nsc_ctrl_asserts #(.WHR_CYC(WHR_CYC), .ADL_CYC(ADL_CYC)) u_nsc_ctrl_asserts (
   .pclk, .presetn, .psel, .penable, .paddr, .pready, .pslverr, .nand_ce_n, .nand_cle,
   .nand_ale, .nand_we_n, .nand_re_n, .nand_io_o, .nand_io_oe);
`default_nettype wire

// >>> bench/nsc_nand_model.sv
// Purpose: behavioural two-die nand target for the controller bench
// Assumes: strobes latch on rising we_n, output on falling re_n
// Notes:   only the low column byte is kept; cache is 256 bytes
`timescale 1ns/1ps
`default_nettype none
module nsc_nand_model
(
   input  wire logic       ce_n,
   input  wire logic       cle,
   input  wire logic       ale,
   input  wire logic       we_n,
   input  wire logic       re_n,
   input  wire logic [7:0] io_o,
   input  wire logic       busy0,
   output logic [7:0]      io_i,
   output logic            rb_n
);
   logic [7:0] mem_r [256];
   logic [7:0] sr [2];
   logic [7:0] cmd_r = 8'h00;
   logic [7:0] col_r = 8'h00;
   logic [2:0] acnt_r = 3'h0;
   logic       sel_r = 1'b0;
   logic [1:0] mode_r = 2'h0;    // 0 none, 1 status, 2 out, 3 in
   // ready bits cover the whole die; fail bits stay at pass
   assign sr[0] = {1'b1, ~busy0, ~busy0, 5'h00};
   assign sr[1] = 8'he0;
   assign rb_n  = sr[sel_r][6];
   initial
   begin
      io_i = 8'h00;
      for (int i = 0; i < 256; i++)
         mem_r[i] = i[7:0] ^ 8'ha5;
   end
   // command, address and data-in latch
   always @(posedge we_n)
      if (!ce_n && cle)
      begin
         cmd_r  <= io_o;
         acnt_r <= 3'h0;
         mode_r <= 2'h0;
         if (io_o == 8'h70)
            mode_r <= 2'h1;
         if (io_o == 8'h00)
            mode_r <= 2'h2;
         if (io_o == 8'he0 && sr[sel_r][6] && (cmd_r == 8'h05 || (cmd_r == 8'h06 && sr[sel_r][5])))
            mode_r <= 2'h2;
      end
      else if (!ce_n && ale)
      begin
         acnt_r <= acnt_r + 3'h1;
         if (acnt_r == 3'h0 && cmd_r != 8'h78)
            col_r <= io_o;
         if ((cmd_r == 8'h78 && acnt_r == 3'h2) || (cmd_r == 8'h06 && acnt_r == 3'h4))
            sel_r <= io_o[0];
         if (cmd_r == 8'h78 && acnt_r == 3'h2)
            mode_r <= 2'h1;
         if (cmd_r == 8'h85 && acnt_r == 3'h1 && sr[sel_r][6])
            mode_r <= 2'h3;
      end
      else if (!ce_n && mode_r == 2'h3)
      begin
         mem_r[col_r] <= io_o;
         col_r        <= col_r + 8'h01;
      end
   // output on falling re_n; a released bus shows the inverse
   always @(negedge re_n)
      if (!ce_n && mode_r == 2'h1)
         io_i <= sr[sel_r];
      else if (!ce_n && mode_r == 2'h2)
      begin
         io_i  <= mem_r[col_r] ^ {7'h00, sel_r};
         col_r <= col_r + 8'h01;
      end
   always @(posedge re_n)
      io_i <= ~io_i;
endmodule : nsc_nand_model
`default_nettype wire

// >>> bench/tb.sv
// Purpose: self-checking bench for the nand status / column controller
// Assumes: zero-wait apb slave, software polls the busy bit
// Notes:   die 1 is always ready; die 0 busy is steered by busy0
`timescale 1ns/1ps
`default_nettype none
`include "nsc_defs.svh"
module tb;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        ce_n, cle, ale, we_n, re_n, io_oe, rb_n;
   logic [7:0]  io_o, io_i;
   logic        busy0 = 1'b0;
   logic [31:0] rd;
   logic        slv;
   int          miscompares = 0;
   int          cmp_count = 0;
   nsc_ctrl #(.WHR_CYC(3), .ADL_CYC(4)) u_nsc_ctrl (.pclk, .presetn, .psel, .penable, .pwrite,
      .paddr, .pwdata, .prdata, .pready, .pslverr, .nand_ce_n(ce_n), .nand_cle(cle), .nand_ale(ale),
      .nand_we_n(we_n), .nand_re_n(re_n), .nand_io_o(io_o), .nand_io_oe(io_oe), .nand_io_i(io_i),
      .nand_rb_n(rb_n));
   nsc_nand_model u_nsc_nand_model (.ce_n, .cle, .ale, .we_n, .re_n, .io_o, .busy0, .io_i, .rb_n);
   always #10 pclk = ~pclk;
   // one apb transfer; an edge passes first so psel never toggles twice
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 1'b0;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do @(posedge pclk); while (pready !== 1'b1 && ++n < 50);
      if (n >= 50)
         miscompares++;
      rd = prdata;
      slv = pslverr;
      psel <= 1'b0; penable <= 1'b0;
   endtask : apb
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      cmp_count++;
      if (g !== e)
      begin
         miscompares++;
         $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk
   // start one op and poll busy, bounded
   task automatic run_op(input logic [2:0] op, input logic multi);
      int n;
      apb(1'b1, `NSC_OFF_CTRL, {26'h0, multi, 1'b1, 1'b0, op});
      n = 0;
      do apb(1'b0, `NSC_OFF_STAT, 32'h0); while (rd[0] !== 1'b0 && ++n < 200);
      if (n >= 200)
         miscompares++;
      apb(1'b0, `NSC_OFF_STAT, 32'h0);
   endtask : run_op
   task automatic t_reset;
      apb(1'b0, `NSC_OFF_STAT, 32'h0);
      chk(rd, `NSC_RST_WORD);
      apb(1'b0, 12'h0fc, 32'h0);
      chk({31'h0, slv}, 32'h1);
      chk(rd, 32'h0);
   endtask : t_reset
   // multi-die status and column-read ops before any enhanced status are refused
   task automatic t_refuse;
      logic [2:0] ops [3] = '{3'h0, 3'h3, 3'h4};
      foreach (ops[i])
      begin
         run_op(ops[i], 1'b1);
         chk(rd[1], 1'b1);
      end
   endtask : t_refuse
   task automatic t_status70;
      busy0 <= 1'b1;
      run_op(3'h0, 1'b0);
      run_op(3'h6, 1'b0);
      chk(rd[15:8], 8'h80);
      chk(rd[3:2], 2'h1);
      chk(rd[5], 1'b1);
      busy0 <= 1'b0;
   endtask : t_status70
   // column change on die 0, then a sequential second byte
   task automatic t_rand05;
      apb(1'b1, `NSC_OFF_ADDR, 32'h0000_0123);
      run_op(3'h3, 1'b0);
      run_op(3'h6, 1'b0);
      apb(1'b0, `NSC_OFF_DATA, 32'h0);
      chk(rd[7:0], 8'h23 ^ 8'ha5);
      run_op(3'h6, 1'b0);
      apb(1'b0, `NSC_OFF_DATA, 32'h0);
      chk(rd[7:0], 8'h24 ^ 8'ha5);
   endtask : t_rand05
   // plane / die select on die 1 at the last byte of the low column page
   task automatic t_rand06;
      apb(1'b1, `NSC_ROW_OFF, 32'h0001_0000);
      apb(1'b1, `NSC_OFF_ADDR, 32'h0000_07ff);
      run_op(3'h4, 1'b0);
      run_op(3'h6, 1'b0);
      apb(1'b0, `NSC_OFF_DATA, 32'h0);
      chk(rd[7:0], 8'hff ^ 8'ha5 ^ 8'h01);
      chk(u_nsc_nand_model.sel_r, 1'b1);
   endtask : t_rand06
   // enhanced status on die 1, read mode, enhanced status on die 0, then plain status follows the last die
   task automatic t_status78;
      run_op(3'h1, 1'b0);
      run_op(3'h6, 1'b0);
      chk(rd[15:8], 8'he0);
      run_op(3'h2, 1'b0);
      run_op(3'h6, 1'b0);
      apb(1'b0, `NSC_OFF_DATA, 32'h0);
      chk(rd[7:0], 8'ha5 ^ 8'h01);
      busy0 <= 1'b1;
      apb(1'b1, `NSC_ROW_OFF, 32'h0000_0000);
      run_op(3'h1, 1'b1);
      run_op(3'h6, 1'b1);
      chk(rd[15:8], 8'h80);
      run_op(3'h0, 1'b1);
      run_op(3'h6, 1'b1);
      chk(rd[15:8], 8'h80);
      busy0 <= 1'b0;
   endtask : t_status78
   // write one byte at a new column and read it back
   task automatic t_rand85;
      apb(1'b1, `NSC_OFF_ADDR, 32'h0000_0040);
      apb(1'b1, `NSC_OFF_WDATA, 32'h0000_003c);
      run_op(3'h5, 1'b0);
      chk(rd[3:2], 2'h3);
      run_op(3'h7, 1'b0);
      run_op(3'h3, 1'b0);
      run_op(3'h6, 1'b0);
      apb(1'b0, `NSC_OFF_DATA, 32'h0);
      chk(rd[7:0], 8'h3c);
   endtask : t_rand85
   task automatic finish_test;
      $display("compares=%0d miscompares=%0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : finish_test
   // main sequence
   initial
   begin
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_refuse();
      t_status70();
      t_rand05();
      t_rand06();
      t_status78();
      t_rand85();
      finish_test();
   end
   // watchdog, far beyond the few hundred cycles the run needs
   initial
   begin
      #1_000_000;
      miscompares++;
      finish_test();
   end
endmodule : tb
`default_nettype wire

// >>> verilog/nsc_ctrl.sv
// Purpose: host-side controller issuing nand status and column commands
// Assumes: apb slave for software, asynchronous nand pins toward target
// Notes:   one command sequence at a time; software polls busy
`timescale 1ns/1ps
`default_nettype none
`include "nsc_defs.svh"
module nsc_ctrl
   import nsc_pkg::*;
#(
   parameter int WHR_CYC = `NSC_WHR_CYC,
   parameter int ADL_CYC = `NSC_ADL_CYC
)
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   output logic             nand_ce_n,
   output logic             nand_cle,
   output logic             nand_ale,
   output logic             nand_we_n,
   output logic             nand_re_n,
   output logic [7:0]       nand_io_o,
   output logic             nand_io_oe,
   input  wire logic [7:0]  nand_io_i,
   input  wire logic        nand_rb_n
);
   initial
   begin
      if (WHR_CYC < 1 || WHR_CYC > 255 || ADL_CYC < 1 || ADL_CYC > 255)
         $error("nsc_ctrl: wait counts out of range");
   end

   typedef enum logic [2:0] {
      CS_IDLE, CS_ISSUE, CS_WAIT, CS_GAP, CS_FETCH, CS_DONE
   } nsc_cs_t;

   // software registers and sequence state
   logic [31:0]  ctrl_r, ctrl_nxt;
   logic [31:0]  col_r, col_nxt;
   logic [31:0]  row_r, row_nxt;
   logic [7:0]   wdat_r, wdat_nxt;
   logic [7:0]   rdat_r, rdat_nxt;
   logic [7:0]   last_sr_r, last_sr_nxt;
   logic [1:0]   mode_r, mode_nxt;     // 0 none, 1 status, 2 out, 3 in
   logic         err_r, err_nxt;
   logic         sel_ok_r, sel_ok_nxt; // die chosen since interleaving
   nsc_cs_t      cs_r, cs_nxt;
   logic [2:0]   step_r, step_nxt;
   logic [7:0]   gap_r, gap_nxt;

   logic         seq_ready;
   logic         seq_done;
   logic [7:0]   seq_rd;
   nsc_pins_t    pins;
   logic         seq_valid;
   nsc_cyc_req_t seq_req;
   logic         last_step;
   logic [7:0]   gap_need;

   nsc_op_t op;
   assign op = nsc_op_t'(ctrl_r[`NSC_CTRL_OP_LSB +: 3]);

   nsc_pin_seq #(
      .STROBE_CYC (`NSC_WP_CYC)
   ) u_seq (
      .pclk      (pclk),
      .presetn   (presetn),
      .req_valid (seq_valid),
      .req       (seq_req),
      .req_ready (seq_ready),
      .done      (seq_done),
      .rd_data   (seq_rd),
      .io_i      (nand_io_i),
      .pins      (pins)
   );

   // cycle list per operation: one command, columns, rows, optional confirm; byte read/write is one data cycle only
   always_comb
   begin
      seq_req.kind = NSC_CYC_CMD;
      seq_req.data = 8'h00;
      last_step    = 1'b0;
      gap_need     = 8'h00;
      case (op)
         NSC_OP_STATUS:
         begin
            seq_req.data = `NSC_CMD_STATUS;
            last_step    = 1'b1;
            gap_need     = 8'(WHR_CYC);
         end
         NSC_OP_STATUS_EN:
         begin
            if (step_r == 3'd0)
               seq_req.data = `NSC_CMD_STATUS_EN;
            else
            begin
               seq_req.kind = NSC_CYC_ADDR;
               seq_req.data = row_r[8*(step_r-3'd1) +: 8];     // page, block, die
            end
            last_step = (step_r == 3'd3);
            gap_need  = 8'(WHR_CYC);
         end
         NSC_OP_READMODE:
         begin
            seq_req.data = `NSC_CMD_READMODE;
            last_step    = 1'b1;
         end
         NSC_OP_RDREAD, NSC_OP_RDREAD2P:
         begin
            if (step_r == 3'd0)
               seq_req.data = (op == NSC_OP_RDREAD) ? `NSC_CMD_RDREAD : `NSC_CMD_RDREAD2P;
            else if (step_r <= 3'd2)
            begin
               seq_req.kind = NSC_CYC_ADDR;
               seq_req.data = col_r[8*(step_r-3'd1) +: 8];
            end
            else if (op == NSC_OP_RDREAD2P && step_r <= 3'd5)
            begin
               seq_req.kind = NSC_CYC_ADDR;
               seq_req.data = row_r[8*(step_r-3'd3) +: 8];
            end
            else
               seq_req.data = `NSC_CMD_CONFIRM;
            last_step = (op == NSC_OP_RDREAD) ? (step_r == 3'd3) : (step_r == 3'd6);
            gap_need  = 8'(WHR_CYC);
         end
         NSC_OP_RDINPUT:
         begin
            if (step_r == 3'd0)
               seq_req.data = `NSC_CMD_RDINPUT;
            else
            begin
               seq_req.kind = NSC_CYC_ADDR;
               seq_req.data = col_r[8*(step_r-3'd1) +: 8];
            end
            last_step = (step_r == 3'd2);
            gap_need  = 8'(ADL_CYC);
         end
         NSC_OP_RDBYTE:
         begin
            seq_req.kind = NSC_CYC_DOUT;
            last_step    = 1'b1;
         end
         default:
         begin
            seq_req.kind = NSC_CYC_DIN;
            seq_req.data = wdat_r;
            last_step    = 1'b1;
         end
      endcase
   end

   assign seq_valid = (cs_r == CS_ISSUE);

   // apb access and command sequencing
   always_comb
   begin
      ctrl_nxt    = ctrl_r;
      col_nxt     = col_r;
      row_nxt     = row_r;
      wdat_nxt    = wdat_r;
      rdat_nxt    = rdat_r;
      last_sr_nxt = last_sr_r;
      mode_nxt    = mode_r;
      err_nxt     = err_r;
      sel_ok_nxt  = sel_ok_r;
      cs_nxt      = cs_r;
      step_nxt    = step_r;
      gap_nxt     = gap_r;
      if (psel && penable && pwrite && cs_r == CS_IDLE)
      begin
         case (paddr)
            `NSC_OFF_CTRL:
            begin
               ctrl_nxt = pwdata;
               if (pwdata[`NSC_CTRL_GO_BIT])
               begin
                  err_nxt = 1'b0;
                  // in multi-die mode status and column-read ops need the die chosen first
                  if (pwdata[`NSC_CTRL_MULTI] && !sel_ok_r &&
                      (pwdata[2:0] == 3'(NSC_OP_STATUS) || pwdata[2:0] == 3'(NSC_OP_RDREAD) ||
                       pwdata[2:0] == 3'(NSC_OP_RDREAD2P)))
                     err_nxt = 1'b1;
                  else
                  begin
                     cs_nxt   = CS_ISSUE;
                     step_nxt = 3'd0;
                  end
               end
            end
            `NSC_OFF_ADDR:  col_nxt  = pwdata;
            `NSC_ROW_OFF:   row_nxt  = pwdata;
            `NSC_OFF_WDATA: wdat_nxt = pwdata[7:0];
            default: ;
         endcase
      end
      case (cs_r)
         CS_ISSUE:
            if (seq_ready)
               cs_nxt = CS_WAIT;
         CS_WAIT:
            if (seq_done)
            begin
               if (step_r == 3'd0 && seq_req.kind == NSC_CYC_CMD)
                  mode_nxt = 2'd0;
               if (seq_req.kind == NSC_CYC_DOUT)
               begin
                  rdat_nxt = seq_rd;
                  if (mode_r == 2'd1)
                     last_sr_nxt = seq_rd;
               end
               if (last_step)
               begin
                  gap_nxt = gap_need;
                  cs_nxt  = (gap_need == 8'h00) ? CS_DONE : CS_GAP;
               end
               else
               begin
                  step_nxt = step_r + 3'd1;
                  cs_nxt   = CS_ISSUE;
               end
            end
         CS_GAP:
         begin
            if (gap_r <= 8'h01)
               cs_nxt = CS_DONE;
            gap_nxt = gap_r - 8'h01;
         end
         CS_DONE:
         begin
            case (op)
               NSC_OP_STATUS:    mode_nxt = 2'd1;
               NSC_OP_STATUS_EN:
               begin
                  mode_nxt   = 2'd1;
                  sel_ok_nxt = 1'b1;
               end
               NSC_OP_READMODE, NSC_OP_RDREAD, NSC_OP_RDREAD2P: mode_nxt = 2'd2;
               NSC_OP_RDINPUT:   mode_nxt = 2'd3;
               default: ;
            endcase
            if (!ctrl_r[`NSC_CTRL_MULTI])
               sel_ok_nxt = 1'b1;
            ctrl_nxt[`NSC_CTRL_GO_BIT] = 1'b0;
            cs_nxt = CS_IDLE;
         end
         default: ;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctrl_r    <= `NSC_RST_WORD;
         col_r     <= `NSC_RST_WORD;
         row_r     <= `NSC_RST_WORD;
         wdat_r    <= 8'h00;
         rdat_r    <= 8'h00;
         last_sr_r <= 8'h00;
         mode_r    <= 2'd0;
         err_r     <= 1'b0;
         sel_ok_r  <= 1'b0;
         cs_r      <= CS_IDLE;
         step_r    <= 3'd0;
         gap_r     <= 8'h00;
      end
      else
      begin
         ctrl_r    <= ctrl_nxt;
         col_r     <= col_nxt;
         row_r     <= row_nxt;
         wdat_r    <= wdat_nxt;
         rdat_r    <= rdat_nxt;
         last_sr_r <= last_sr_nxt;
         mode_r    <= mode_nxt;
         err_r     <= err_nxt;
         sel_ok_r  <= sel_ok_nxt;
         cs_r      <= cs_nxt;
         step_r    <= step_nxt;
         gap_r     <= gap_nxt;
      end
   end

   // read mux; zero wait state, unmapped reads zero with slverr
   always_comb
   begin
      prdata  = 32'h0000_0000;
      pslverr = 1'b0;
      case (paddr)
         `NSC_OFF_CTRL:  prdata = ctrl_r;
         `NSC_OFF_ADDR:  prdata = col_r;
         `NSC_ROW_OFF:   prdata = row_r;
         `NSC_OFF_WDATA: prdata = {24'h000000, wdat_r};
         `NSC_OFF_DATA:  prdata = {24'h000000, rdat_r};
         // ready/busy pin follows cache-ready bit, shown beside last status
         `NSC_OFF_STAT:  prdata = {16'h0000, last_sr_r, 2'b00, !nand_rb_n,
                                   sel_ok_r, mode_r, err_r, (cs_r != CS_IDLE)};
         default:        pslverr = psel && penable;
      endcase
   end
   assign pready = 1'b1;

   assign nand_ce_n  = pins.ce_n;
   assign nand_cle   = pins.cle;
   assign nand_ale   = pins.ale;
   assign nand_we_n  = pins.we_n;
   assign nand_re_n  = pins.re_n;
   assign nand_io_o  = pins.io_o;
   assign nand_io_oe = pins.io_oe;
endmodule : nsc_ctrl
`default_nettype wire

// >>> verilog/nsc_defs.svh
// Purpose: constants for the nand status / column command controller
// Assumes: 50 MHz pclk, 32-bit apb register words
// Notes:   offsets are byte addresses of the controller's own registers
`ifndef NSC_DEFS_SVH
`define NSC_DEFS_SVH
// controller register offsets
`define NSC_OFF_CTRL      12'h000
`define NSC_OFF_ADDR      12'h004
`define NSC_OFF_STAT      12'h008
`define NSC_OFF_DATA      12'h00c
`define NSC_OFF_WDATA     12'h010
// ctrl field positions
`define NSC_CTRL_OP_LSB   0
`define NSC_CTRL_GO_BIT   4
`define NSC_CTRL_MULTI    5
// addr field positions: column [15:0], row [39:16] split over two regs
`define NSC_ROW_OFF       12'h014
// opcodes on the nand command cycle
`define NSC_CMD_STATUS    8'h70
`define NSC_CMD_STATUS_EN 8'h78
`define NSC_CMD_READMODE  8'h00
`define NSC_CMD_RDREAD    8'h05
`define NSC_CMD_RDREAD2P  8'h06
`define NSC_CMD_CONFIRM   8'he0
`define NSC_CMD_RDINPUT   8'h85
// status bit positions
`define NSC_SR_RDY        6
`define NSC_SR_ARRAY_READY_FLAG       5
// timing in ns and derived cycles at 20 ns
`define NSC_CLK_NS        20
`define NSC_T_WHR_NS      60
`define NSC_T_ADL_NS      70
`define NSC_T_WP_NS       20
`define NSC_WHR_CYC       ((`NSC_T_WHR_NS + `NSC_CLK_NS - 1) / `NSC_CLK_NS)
`define NSC_ADL_CYC       ((`NSC_T_ADL_NS + `NSC_CLK_NS - 1) / `NSC_CLK_NS)
`define NSC_WP_CYC        ((`NSC_T_WP_NS + `NSC_CLK_NS - 1) / `NSC_CLK_NS)
// reset values
`define NSC_RST_WORD      32'h0000_0000
`endif

// >>> verilog/nsc_pin_seq.sv
// Purpose: one asynchronous nand bus cycle (command, address, data in/out)
// Assumes: pin inputs synchronous to pclk
// Notes:   strobe low time is a whole number of clocks
`timescale 1ns/1ps
`default_nettype none
`include "nsc_defs.svh"
module nsc_pin_seq
   import nsc_pkg::*;
#(
   parameter int STROBE_CYC = `NSC_WP_CYC
)
(
   input  wire logic         pclk,
   input  wire logic         presetn,
   input  wire logic         req_valid,
   input  var  nsc_cyc_req_t req,
   output logic              req_ready,
   output logic              done,
   output logic [7:0]        rd_data,
   input  wire logic [7:0]   io_i,
   output nsc_pins_t         pins
);
   initial
   begin
      if (STROBE_CYC < 1 || STROBE_CYC > 255)
         $error("nsc_pin_seq: STROBE_CYC out of range");
   end

   typedef enum logic [1:0] {PS_IDLE, PS_LOW, PS_HIGH} nsc_ps_t;
   nsc_ps_t      st_r, st_nxt;
   logic [7:0]   cnt_r, cnt_nxt;
   nsc_cyc_req_t cur_r, cur_nxt;
   logic [7:0]   rd_r, rd_nxt;
   logic         done_r, done_nxt;

   // strobe low for STROBE_CYC, then high one cycle to finish
   always_comb
   begin
      st_nxt   = st_r;
      cnt_nxt  = cnt_r;
      cur_nxt  = cur_r;
      rd_nxt   = rd_r;
      done_nxt = 1'b0;
      case (st_r)
         PS_IDLE:
         begin
            if (req_valid)
            begin
               cur_nxt = req;
               cnt_nxt = 8'(STROBE_CYC - 1);
               st_nxt  = PS_LOW;
            end
         end
         PS_LOW:
         begin
            if (cnt_r == 8'h00)
            begin
               if (cur_r.kind == NSC_CYC_DOUT)
                  rd_nxt = io_i; // sampled before re rises
               st_nxt = PS_HIGH;
            end
            else
               cnt_nxt = cnt_r - 8'h01;
         end
         PS_HIGH:
         begin
            done_nxt = 1'b1;
            st_nxt   = PS_IDLE;
         end
         default: st_nxt = PS_IDLE;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         st_r   <= PS_IDLE;
         cnt_r  <= 8'h00;
         cur_r  <= '0;
         rd_r   <= 8'h00;
         done_r <= 1'b0;
      end
      else
      begin
         st_r   <= st_nxt;
         cnt_r  <= cnt_nxt;
         cur_r  <= cur_nxt;
         rd_r   <= rd_nxt;
         done_r <= done_nxt;
      end
   end

   assign req_ready = (st_r == PS_IDLE);
   assign done      = done_r;
   assign rd_data   = rd_r;

   // cle/ale held through the whole cycle, io driven only on host writes
   always_comb
   begin
      pins.ce_n  = 1'b0;
      pins.cle   = (st_r != PS_IDLE) && (cur_r.kind == NSC_CYC_CMD);
      pins.ale   = (st_r != PS_IDLE) && (cur_r.kind == NSC_CYC_ADDR);
      pins.we_n  = !((st_r == PS_LOW) && (cur_r.kind != NSC_CYC_DOUT));
      pins.re_n  = !((st_r == PS_LOW) && (cur_r.kind == NSC_CYC_DOUT));
      pins.io_o  = cur_r.data;
      pins.io_oe = (st_r != PS_IDLE) && (cur_r.kind != NSC_CYC_DOUT);
   end
endmodule : nsc_pin_seq
`default_nettype wire

// >>> verilog/nsc_pkg.sv
// Purpose: types for the nand status / column command controller
// Assumes: nothing beyond the defs header
// Notes:   opcodes and offsets live in nsc_defs.svh
package nsc_pkg;
   // operation chosen by software
   typedef enum logic [2:0] {
      NSC_OP_STATUS, NSC_OP_STATUS_EN, NSC_OP_READMODE,
      NSC_OP_RDREAD, NSC_OP_RDREAD2P, NSC_OP_RDINPUT, NSC_OP_RDBYTE, NSC_OP_WRBYTE
   } nsc_op_t;
   // kind of one bus cycle on the nand pins
   typedef enum logic [1:0] {
      NSC_CYC_CMD, NSC_CYC_ADDR, NSC_CYC_DIN, NSC_CYC_DOUT
   } nsc_cyc_t;
   // request to the pin sequencer
   typedef struct packed {
      nsc_cyc_t   kind;
      logic [7:0] data;
   } nsc_cyc_req_t;
   // nand pin outputs
   typedef struct packed {
      logic       ce_n;
      logic       cle;
      logic       ale;
      logic       we_n;
      logic       re_n;
      logic [7:0] io_o;
      logic       io_oe;
   } nsc_pins_t;
endpackage : nsc_pkg
